// ==== wdts_top.sv ====
// wdts_top: watchdog timeout supervisor with early warning interrupt
// assumes software bits arrive as plain control inputs, one clock domain
`timescale 1ns/10ps
`default_nettype none
module wdts_top
	import wdts_pkg::*;
(
	// clock and power-on reset
	input  wire logic        mclk_in,
	input  wire logic        srst_in,
	// system clock divider mode
	input  wire logic [2:0]  cd_in,
	// control register write port
	input  wire logic        ctl_wr_in,
	input  wire logic [1:0]  ctl_sel_in,
	input  wire logic        ctl_ie_in,
	input  wire logic        restart_in,
	input  wire logic        flag_clr_in,
	input  wire logic        rstf_clr_in,
	// status and control readback
	output logic [5:0]       watchdog_control_register_out,
	// system effects
	output logic             irq_out,
	output logic             sys_reset_out,
	output logic [15:0]      reset_vector_out
);

	logic                  tick;
	logic [WDTS_CNT_W-1:0] cnt_q;
	logic [1:0]            sel_q;
	logic                  ie_q;
	logic                  iflag_q;
	logic                  watchdog_reset_flag_q;
	logic                  sysrst_q;
	logic [WDTS_CNT_W-1:0] limit;
	logic                  at_warn;
	logic                  at_limit;

	// timeout length for an interval code
	function automatic logic [WDTS_CNT_W-1:0] wdts_limit(input logic [1:0] s);
		wdts_limit = WDTS_CNT_W'(1) << (WDTS_EXP_0 + WDTS_EXP_STEP * s);
	endfunction

	// ==========================================================
	// system clock tick
	wdts_sysclk_tick u_tick (
		.mclk_in  (mclk_in),
		.srst_in  (srst_in),
		.cd_in    (cd_in),
		.tick_out (tick)
	);

	assign limit    = wdts_limit(sel_q);
	// warn one count earlier so the flag edge leads the reset edge by 512 ticks
	assign at_warn  = tick &&
		cnt_q == limit - WDTS_CNT_W'(WDTS_WARN_CLKS + 1);
	assign at_limit = tick && cnt_q == limit - WDTS_CNT_W'(1);

	// ==========================================================
	// control register fields
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || sysrst_q)
		begin
			sel_q <= WDTS_SEL_RST;
			ie_q  <= 1'b0;
		end
		else if (ctl_wr_in)
		begin
			sel_q <= ctl_sel_in;
			ie_q  <= ctl_ie_in;
		end
	end

	// free-running counter; the watchdog reset itself also clears it
	// a shorter interval written past the current count runs on to wrap
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || sysrst_q || restart_in)
			cnt_q <= '0;
		else if (tick)
			cnt_q <= cnt_q + WDTS_CNT_W'(1);
	end

	// early warning flag; set wins over clear
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || sysrst_q)
			iflag_q <= 1'b0;
		else if (at_warn && !restart_in)
			iflag_q <= 1'b1;
		else if (flag_clr_in)
			iflag_q <= 1'b0;
	end

	// one-cycle system reset at timeout
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			sysrst_q <= 1'b0;
		else
			sysrst_q <= at_limit && !restart_in;
	end

	// reset source flag survives the watchdog reset, cleared on power-on
	always_ff @(posedge mclk_in)
	begin
		if (srst_in)
			watchdog_reset_flag_q <= 1'b0;
		else if (sysrst_q)
			watchdog_reset_flag_q <= 1'b1;
		else if (rstf_clr_in)
			watchdog_reset_flag_q <= 1'b0;
	end

	// ==========================================================
	// outputs
	assign irq_out          = iflag_q && ie_q;
	assign sys_reset_out    = sysrst_q;
	assign reset_vector_out = WDTS_RESET_VEC;
	assign watchdog_control_register_out =
		{watchdog_reset_flag_q, iflag_q, ie_q, sel_q, 1'b0};

	// ==========================================================
	// checks
	// clocks since the counter was last cleared; saturates rather than wraps
	logic [WDTS_CNT_W-1:0] since_q;
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || restart_in || sysrst_q)
			since_q <= '0;
		else if (since_q != '1)
			since_q <= since_q + WDTS_CNT_W'(1);
	end

	// ticks since the warning fired; zero means no warning is pending.
	// a control write voids it, since the limit may have moved under it.
	// counting ticks, not clocks, keeps the check valid in every divider mode
	logic [9:0] lead_q;
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || sysrst_q || restart_in || ctl_wr_in)
			lead_q <= '0;
		else if (at_warn)
			lead_q <= 10'h001;
		else if (tick && lead_q != '0 && lead_q != '1)
			lead_q <= lead_q + 10'h001;
	end

	// rule checks, one clock domain, all but a_sel_reset disabled during power-on reset
	a_reset_no_early: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		sysrst_q |-> $past(at_limit) && !$past(restart_in))
		else $error("watchdog reset without timeout");

	a_restart_clears: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		restart_in |=> cnt_q == '0)
		else $error("restart did not clear counter");

	a_warn_lead: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		at_limit && !restart_in && lead_q != '0
		|-> lead_q == 10'(WDTS_WARN_CLKS))
		else $error("warning not 512 ticks before reset");

	a_flag_sets: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		at_warn && !restart_in && !sysrst_q |=> iflag_q)
		else $error("warning flag not set");

	a_flag_only_warn: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		$rose(iflag_q) |-> $past(at_warn) && !$past(restart_in))
		else $error("warning flag set outside the warning point");

	a_rstf_sets: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		sysrst_q |=> watchdog_reset_flag_q)
		else $error("reset flag not set");

	a_min_timeout: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		$rose(sysrst_q) |-> since_q >= WDTS_CNT_W'(4095))
		else $error("timeout shorter than shortest interval");

	a_sel_reset: assert property (
		@(posedge mclk_in)
		$past(srst_in) |-> sel_q == WDTS_SEL_RST && !ie_q)
		else $error("interval not shortest after reset");

	a_irq_gate: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		irq_out |-> iflag_q && ie_q)
		else $error("interrupt without enable");

	a_vector: assert property (
		@(posedge mclk_in) disable iff (srst_in)
		sysrst_q |-> reset_vector_out == 16'h8000)
		else $error("wrong restart address");

	// main scenarios seen at least once
	c_timeout: cover property (@(posedge mclk_in) disable iff (srst_in)
		$rose(sysrst_q));
	c_warn_irq: cover property (@(posedge mclk_in) disable iff (srst_in)
		$rose(irq_out));
	c_restart_late: cover property (@(posedge mclk_in) disable iff (srst_in)
		iflag_q && restart_in);
	c_slow_timeout: cover property (@(posedge mclk_in) disable iff (srst_in)
		$rose(sysrst_q) && cd_in != 3'h0);

endmodule
`default_nettype wire

// ==== wdts_pkg.sv ====
// wdts_pkg: constants shared by the watchdog timeout supervisor files
// assumes a single system clock domain and a synchronous reset
`default_nettype none
package wdts_pkg;

	// ==========================================================
	// counter and interval figures
	localparam int unsigned WDTS_CNT_W       = 22;
	localparam int unsigned WDTS_SEL_W       = 2;
	localparam int unsigned WDTS_EXP_0       = 12;
	localparam int unsigned WDTS_EXP_STEP    = 3;
	localparam int unsigned WDTS_WARN_CLKS   = 512;
	localparam logic [1:0]  WDTS_SEL_RST     = 2'h0;
	localparam logic [15:0] WDTS_RESET_VEC   = 16'h8000;

	// ==========================================================
	// system clock divider figures (counter width and the mode code for /256)
	localparam int unsigned WDTS_DIV_W       = 8;
	localparam logic [2:0]  WDTS_CD_PMM      = 3'h4;

endpackage
`default_nettype wire

// ==== wdts_sysclk_tick.sv ====
// wdts_sysclk_tick: turns oscillator clocks into system clock ticks
// assumes mclk_in is the oscillator and cd_in is stable between frames
`timescale 1ns/10ps
`default_nettype none
module wdts_sysclk_tick
	import wdts_pkg::*;
(
	// clock and reset
	input  wire logic       mclk_in,
	input  wire logic       srst_in,
	// divider mode: 0..3 = /1,/2,/4,/8, 4 = /256
	input  wire logic [2:0] cd_in,
	// tick out
	output logic            tick_out
);

	logic [WDTS_DIV_W-1:0] div_q;
	logic [WDTS_DIV_W-1:0] last;

	// terminal count per divider mode
	always_comb
	begin
		case (cd_in)
			3'h0:        last = 8'h00;
			3'h1:        last = 8'h01;
			3'h2:        last = 8'h03;
			3'h3:        last = 8'h07;
			WDTS_CD_PMM: last = 8'hff;
			default:     last = 8'h00;
		endcase
	end

	// divider counter; mode changes move the terminal count at once, mid-frame
	always_ff @(posedge mclk_in)
	begin
		if (srst_in || div_q >= last)
			div_q <= '0;
		else
			div_q <= div_q + 8'h01;
	end

	assign tick_out = (div_q >= last);

endmodule
`default_nettype wire

// ==== wdts_tb.sv ====
// wdts_tb: self-checking bench for wdts_top, timing model from integers
// assumes the package and design files are compiled before this one
`timescale 1ns/10ps
`default_nettype none
module testbench
	import wdts_pkg::*;
;
	logic        mclk_in;
	logic        srst_in;
	logic [2:0]  cd_in;
	logic        ctl_wr_in;
	logic [1:0]  ctl_sel_in;
	logic        ctl_ie_in;
	logic        restart_in;
	logic        flag_clr_in;
	logic        rstf_clr_in;
	logic [5:0]  wcr;
	logic        irq_out;
	logic        sys_reset_out;
	logic [15:0] vec;
	int          err_count;
	int          samples_checked;
	int          bad;
	int          steps;
	logic [1:0]  rsel;
	logic        rie;

	wdts_top u_dut (.mclk_in(mclk_in), .srst_in(srst_in), .cd_in(cd_in),
		.ctl_wr_in(ctl_wr_in), .ctl_sel_in(ctl_sel_in),
		.ctl_ie_in(ctl_ie_in), .restart_in(restart_in),
		.flag_clr_in(flag_clr_in), .rstf_clr_in(rstf_clr_in),
		.watchdog_control_register_out(wcr), .irq_out(irq_out),
		.sys_reset_out(sys_reset_out), .reset_vector_out(vec));

	// ==========================================================
	// clock, 5 ns period
	initial
	begin
		mclk_in = 1'b0;
		forever #2.5 mclk_in = ~mclk_in;
	end

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			err_count++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic tally_and_finish();
		$display("checks=%0d mismatches=%0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// load select and enable, then one restart; n counts edges after it
	task automatic run_wd(input logic [1:0] s, input logic ie,
		input logic [2:0] cd, input bit full);
		int n;
		int wn;
		int dv;
		int lim;
		dv = (cd == 3'h4) ? 256 : (1 << cd);
		lim = (1 << (WDTS_EXP_0 + WDTS_EXP_STEP * s)) * dv;
		@(posedge mclk_in);
		cd_in <= cd;
		ctl_wr_in <= 1'b1;
		ctl_sel_in <= s;
		ctl_ie_in <= ie;
		@(posedge mclk_in);
		ctl_wr_in <= 1'b0;
		restart_in <= 1'b1;
		@(posedge mclk_in);
		restart_in <= 1'b0;
		#1 check(wcr[3:1], {ie, s});
		n = 0;
		wn = 0;
		while (full && sys_reset_out !== 1'b1 && n < lim + 300)
		begin
			@(posedge mclk_in);
			#1 n++;
			if (wn == 0 && wcr[4] === 1'b1)
				wn = n;
		end
		if (!full)
		begin
			$display("test done sel=%0d ie=%0d cd=%0d", s, ie, cd);
			return;
		end
		check(n > lim - dv && n < lim + dv, 1);
		check(n - wn, WDTS_WARN_CLKS * dv);
		check(irq_out, ie);
		@(posedge mclk_in);
		#1 check(wcr, 6'h20);
		check(vec, 16'h8000);
		@(posedge mclk_in);
		rstf_clr_in <= 1'b1;
		@(posedge mclk_in);
		rstf_clr_in <= 1'b0;
		#1 check(wcr[5], 1'b0);
		$display("test done sel=%0d ie=%0d cd=%0d", s, ie, cd);
	endtask

	// ==========================================================
	// hang guard, about 98k cycles against some 93k expected at worst
	initial
	begin
		#490000;
		err_count++;
		tally_and_finish();
	end

	// ==========================================================
	// main sequence
	initial
	begin
		err_count = 0;
		samples_checked = 0;
		srst_in = 1'b1;
		{cd_in, ctl_wr_in, ctl_sel_in, ctl_ie_in} = '0;
		{restart_in, flag_clr_in, rstf_clr_in} = '0;
		bad = $urandom(32'h9942);
		repeat (6) @(posedge mclk_in);
		srst_in <= 1'b0;
		#1 check({wcr, irq_out, sys_reset_out}, 8'h00);
		check(vec, 16'h8000);
		// random restarts below the warning point keep it quiet
		bad = 0;
		repeat (8)
		begin
			@(posedge mclk_in);
			rsel = 2'($urandom);
			rie = 1'($urandom);
			restart_in <= 1'b1;
			ctl_wr_in <= 1'b1;
			ctl_sel_in <= rsel;
			ctl_ie_in <= rie;
			@(posedge mclk_in);
			restart_in <= 1'b0;
			ctl_wr_in <= 1'b0;
			#1 check(wcr[3:1], {rie, rsel});
			repeat ($urandom_range(3000, 100))
			begin
				@(posedge mclk_in);
				#1 bad = bad | sys_reset_out | wcr[4];
			end
		end
		check(bad, 0);
		$display("test done restarts");
		// warning flag rises, then a clear and a restart hold off the reset
		@(posedge mclk_in);
		ctl_wr_in <= 1'b1;
		ctl_sel_in <= 2'h0;
		ctl_ie_in <= 1'b1;
		restart_in <= 1'b1;
		@(posedge mclk_in);
		ctl_wr_in <= 1'b0;
		restart_in <= 1'b0;
		steps = 0;
		while (wcr[4] !== 1'b1 && steps < 4096)
		begin
			@(posedge mclk_in);
			#1 steps++;
		end
		check(steps, (1 << WDTS_EXP_0) - WDTS_WARN_CLKS);
		check(irq_out, 1'b1);
		@(posedge mclk_in);
		flag_clr_in <= 1'b1;
		restart_in <= 1'b1;
		@(posedge mclk_in);
		flag_clr_in <= 1'b0;
		restart_in <= 1'b0;
		#1 check({wcr[4], irq_out, sys_reset_out}, 3'h0);
		$display("test done flag clear");
		run_wd(2'h2, 1'b0, 3'h0, 1'b0);
		run_wd(2'h3, 1'b1, 3'h0, 1'b0);
		run_wd(2'h0, 1'b1, 3'h0, 1'b1);
		run_wd(2'h0, 1'b0, 3'h0, 1'b1);
		run_wd(2'h1, 1'b1, 3'h0, 1'b1);
		run_wd(2'h0, 1'b1, 3'h1, 1'b1);
		run_wd(2'h0, 1'b1, 3'h2, 1'b1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
